/* design/tccie_regs.sv */
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tccie_regs (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic updateEvent,
    input wire logic ch1Event,
    input wire logic commutationGenerate,
    input wire logic breakEvent,
    input wire logic triggerInput,
    input wire logic [1:0] protectionLockLevel,
    input wire logic hasComplOut,
    input wire logic [4:0] newSettings,
    input wire logic settingsWrite,
    output logic [4:0] activeSettings,
    output logic ch1MainIdleLevel,
    output logic ch1ComplIdleLevel,
    output logic chanDmaReq,
    output logic updateDmaReq,
    output logic irq
);
    logic [15:0] ctrl;
    logic [15:0] enables;
    logic [15:0] status;
    logic [4:0] shadow;
    logic trigPrev;

    // address decode
    wire wrCtrl = wr && (addr == tccie_pkg::OFS_CHAN_OUT_CTRL);
    wire wrEn = wr && (addr == tccie_pkg::OFS_IRQ_DMA_EN);
    wire wrSts = wr && (addr == tccie_pkg::OFS_EVENT_STATUS);
    wire locked = (protectionLockLevel != 2'h0);
    wire preloadOn = ctrl[tccie_pkg::CTL_PRELOAD_BIT];
    wire trigRise = triggerInput && !trigPrev;

    // idle bits writable only when unlocked
    wire [15:0] ctrlWmask = locked ? tccie_pkg::CTL_WMASK :
        (tccie_pkg::CTL_WMASK | tccie_pkg::CTL_IDLE_MASK);
    wire [15:0] next_ctrl = (ctrl & ~ctrlWmask) | (wdata & ctrlWmask);

    // preload only for a complementary channel
    wire usePreload = preloadOn && hasComplOut;
    // transfer strobe: commutation, or trigger edge when selected
    wire xfer = commutationGenerate ||
        (ctrl[tccie_pkg::CTL_UPD_SEL_BIT] && trigRise);
    wire [4:0] next_shadow = settingsWrite ? newSettings : shadow;

    // sticky event flags: set wins over write-one clear
    wire [15:0] evVec = {8'h00, breakEvent, 1'b0, commutationGenerate,
        3'h0, ch1Event, updateEvent} & tccie_pkg::STS_MASK;
    wire [15:0] clrVec = wrSts ? (wdata & tccie_pkg::STS_MASK) : 16'h0000;
    wire [15:0] next_status = (status & ~clrVec) | evVec;

    // requests: enable and flag or event
    wire [15:0] irqEnMask = enables & tccie_pkg::STS_MASK;
    assign irq = |(status & irqEnMask);
    wire chanDmaSrc = ctrl[tccie_pkg::CTL_DMA_SEL_BIT] ?
        updateEvent : ch1Event;
    assign chanDmaReq = chanDmaSrc &&
        enables[tccie_pkg::EN_CH1_DMA_BIT];
    assign updateDmaReq = updateEvent &&
        enables[tccie_pkg::EN_UPD_DMA_BIT];
    assign ch1MainIdleLevel = ctrl[tccie_pkg::CTL_MAIN_IDLE_BIT];
    assign ch1ComplIdleLevel = ctrl[tccie_pkg::CTL_COMPL_IDLE_BIT];

    // read mux, registered one cycle
    wire [15:0] rdMux =
        (addr == tccie_pkg::OFS_CHAN_OUT_CTRL) ? ctrl :
        (addr == tccie_pkg::OFS_IRQ_DMA_EN) ? enables :
        (addr == tccie_pkg::OFS_EVENT_STATUS) ? status :
        (addr == tccie_pkg::OFS_SHADOW_VIEW) ? {11'h000, shadow} :
        16'h0000;

    // control and enable registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= tccie_pkg::CTL_RESET;
            enables <= tccie_pkg::EN_RESET;
        end else begin
            if (wrCtrl) ctrl <= next_ctrl;
            if (wrEn) enables <= wdata & tccie_pkg::EN_WMASK;
        end
    end

    // settings path: shadow always tracks software writes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shadow <= tccie_pkg::SET_RESET;
            activeSettings <= tccie_pkg::SET_RESET;
        end else begin
            shadow <= next_shadow;
            if (!usePreload) activeSettings <= next_shadow;
            else if (xfer) activeSettings <= shadow;
        end
    end

    // status flags, edge history, read data
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status <= tccie_pkg::STS_RESET;
            trigPrev <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            status <= next_status;
            trigPrev <= triggerInput;
            rdata <= rd ? rdMux : 16'h0000;
        end
    end

    // assertions: all on the kernel clock, quiet while reset is low
    // steps of the settings path, each used by one property
    sequence s_directWrite;
        settingsWrite && !usePreload;
    endsequence

    sequence s_comEdge;
        usePreload && commutationGenerate;
    endsequence

    sequence s_trigEdge;
        usePreload && trigRise && ctrl[tccie_pkg::CTL_UPD_SEL_BIT];
    endsequence

    // preload off: a settings write lands on the next edge
    property p_immediate;
        @(posedge core_clk) disable iff (!rstn)
        s_directWrite |=>
            activeSettings == $past(newSettings);
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("settings not applied at once");

    // shadow always takes the software value
    property p_shadowTrack;
        @(posedge core_clk) disable iff (!rstn)
        settingsWrite |=> shadow == $past(newSettings);
    endproperty
    a_shadowTrack: assert property (p_shadowTrack)
        else $error("shadow missed a write");

    // preload on: nothing moves without a transfer strobe
    property p_hold;
        @(posedge core_clk) disable iff (!rstn)
        (usePreload && !xfer) |=> $stable(activeSettings);
    endproperty
    a_hold: assert property (p_hold)
        else $error("settings changed early");

    // commutation generate copies the shadow across
    property p_comApply;
        @(posedge core_clk) disable iff (!rstn)
        s_comEdge |=> activeSettings == $past(shadow);
    endproperty
    a_comApply: assert property (p_comApply)
        else $error("commutation did not apply");

    // trigger rise copies the shadow when selected
    property p_trig;
        @(posedge core_clk) disable iff (!rstn)
        s_trigEdge |=> activeSettings == $past(shadow);
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger edge missed");

    // trigger rise alone does nothing when not selected
    property p_trigIgnored;
        @(posedge core_clk) disable iff (!rstn)
        (usePreload && trigRise && !commutationGenerate &&
            !ctrl[tccie_pkg::CTL_UPD_SEL_BIT]) |=> $stable(activeSettings);
    endproperty
    a_trigIgnored: assert property (p_trigIgnored)
        else $error("trigger applied unselected");

    // no complementary output: preload bit has no say
    property p_noComplHold;
        @(posedge core_clk) disable iff (!rstn)
        (settingsWrite && !hasComplOut) |=>
            activeSettings == $past(newSettings);
    endproperty
    a_noComplHold: assert property (p_noComplHold)
        else $error("plain channel was preloaded");

    // update select is void while preload is off
    property p_selNeedsPreload;
        @(posedge core_clk) disable iff (!rstn)
        (settingsWrite && !preloadOn) |=>
            activeSettings == $past(newSettings);
    endproperty
    a_selNeedsPreload: assert property (p_selNeedsPreload)
        else $error("update select acted alone");

    // channel dma only from its selected source
    property p_chdma;
        @(posedge core_clk) disable iff (!rstn)
        chanDmaReq |-> enables[tccie_pkg::EN_CH1_DMA_BIT] &&
            (ctrl[tccie_pkg::CTL_DMA_SEL_BIT] ? updateEvent : ch1Event);
    endproperty
    a_chdma: assert property (p_chdma)
        else $error("bad chan dma");

    // dma select clear: compare event raises the request
    property p_chdmaCompare;
        @(posedge core_clk) disable iff (!rstn)
        (ch1Event && enables[tccie_pkg::EN_CH1_DMA_BIT] &&
            !ctrl[tccie_pkg::CTL_DMA_SEL_BIT]) |-> chanDmaReq;
    endproperty
    a_chdmaCompare: assert property (p_chdmaCompare)
        else $error("compare dma missing");

    // dma select set: update event raises the request
    property p_chdmaUpdate;
        @(posedge core_clk) disable iff (!rstn)
        (updateEvent && enables[tccie_pkg::EN_CH1_DMA_BIT] &&
            ctrl[tccie_pkg::CTL_DMA_SEL_BIT]) |-> chanDmaReq;
    endproperty
    a_chdmaUpdate: assert property (p_chdmaUpdate)
        else $error("update dma on channel missing");

    // main idle level follows an unlocked write
    property p_mainIdle;
        @(posedge core_clk) disable iff (!rstn)
        (wrCtrl && !locked) |=> ch1MainIdleLevel ==
            $past(wdata[tccie_pkg::CTL_MAIN_IDLE_BIT]);
    endproperty
    a_mainIdle: assert property (p_mainIdle)
        else $error("main idle level wrong");

    // complementary idle level follows an unlocked write
    property p_complIdle;
        @(posedge core_clk) disable iff (!rstn)
        (wrCtrl && !locked) |=> ch1ComplIdleLevel ==
            $past(wdata[tccie_pkg::CTL_COMPL_IDLE_BIT]);
    endproperty
    a_complIdle: assert property (p_complIdle)
        else $error("compl idle level wrong");

    // locked: idle bits survive any write
    property p_lock;
        @(posedge core_clk) disable iff (!rstn)
        (wrCtrl && locked) |=> (ctrl & tccie_pkg::CTL_IDLE_MASK) ==
            ($past(ctrl) & tccie_pkg::CTL_IDLE_MASK);
    endproperty
    a_lock: assert property (p_lock)
        else $error("idle bits changed");

    // enabled update event raises irq next cycle
    property p_updirq;
        @(posedge core_clk) disable iff (!rstn)
        (updateEvent && enables[tccie_pkg::EN_UPD_IRQ_BIT] && !wrEn)
        |=> irq;
    endproperty
    a_updirq: assert property (p_updirq)
        else $error("no update irq");

    // enabled channel event raises irq next cycle
    property p_ch1irq;
        @(posedge core_clk) disable iff (!rstn)
        (ch1Event && enables[tccie_pkg::EN_CH1_IRQ_BIT] && !wrEn)
        |=> irq;
    endproperty
    a_ch1irq: assert property (p_ch1irq)
        else $error("no channel irq");

    // enabled commutation raises irq next cycle
    property p_comirq;
        @(posedge core_clk) disable iff (!rstn)
        (commutationGenerate && enables[tccie_pkg::EN_COM_IRQ_BIT] &&
            !wrEn) |=> irq;
    endproperty
    a_comirq: assert property (p_comirq)
        else $error("no commutation irq");

    // enabled break raises irq next cycle
    property p_brkirq;
        @(posedge core_clk) disable iff (!rstn)
        (breakEvent && enables[tccie_pkg::EN_BRK_IRQ_BIT] && !wrEn)
        |=> irq;
    endproperty
    a_brkirq: assert property (p_brkirq)
        else $error("no break irq");

    // update dma only with event and enable
    property p_updma;
        @(posedge core_clk) disable iff (!rstn)
        updateDmaReq |-> updateEvent && enables[tccie_pkg::EN_UPD_DMA_BIT];
    endproperty
    a_updma: assert property (p_updma)
        else $error("bad update dma");

    // update dma present whenever both hold
    property p_updmaOn;
        @(posedge core_clk) disable iff (!rstn)
        (updateEvent && enables[tccie_pkg::EN_UPD_DMA_BIT]) |->
            updateDmaReq;
    endproperty
    a_updmaOn: assert property (p_updmaOn)
        else $error("update dma missing");

    // channel dma silent while its enable is clear
    property p_chdmaOff;
        @(posedge core_clk) disable iff (!rstn)
        !enables[tccie_pkg::EN_CH1_DMA_BIT] |-> !chanDmaReq;
    endproperty
    a_chdmaOff: assert property (p_chdmaOff)
        else $error("channel dma while disabled");

    // update event always leaves the flag set
    property p_updset;
        @(posedge core_clk) disable iff (!rstn)
        updateEvent |=> status[tccie_pkg::EN_UPD_IRQ_BIT];
    endproperty
    a_updset: assert property (p_updset)
        else $error("update flag not set");

    // flag stays until a one is written to it
    property p_updsticky;
        @(posedge core_clk) disable iff (!rstn)
        (status[tccie_pkg::EN_UPD_IRQ_BIT] &&
            !(wrSts && wdata[tccie_pkg::EN_UPD_IRQ_BIT]))
        |=> status[tccie_pkg::EN_UPD_IRQ_BIT];
    endproperty
    a_updsticky: assert property (p_updsticky)
        else $error("flag lost");

    // event beside a clear: the set wins
    property p_setwins;
        @(posedge core_clk) disable iff (!rstn)
        (updateEvent && wrSts && wdata[tccie_pkg::EN_UPD_IRQ_BIT])
        |=> status[tccie_pkg::EN_UPD_IRQ_BIT];
    endproperty
    a_setwins: assert property (p_setwins)
        else $error("clear beat the event");

    // irq only with a flagged and enabled source
    property p_irqcause;
        @(posedge core_clk) disable iff (!rstn)
        irq |-> |(status & enables & tccie_pkg::STS_MASK);
    endproperty
    a_irqcause: assert property (p_irqcause)
        else $error("spurious irq");
endmodule
`default_nettype wire

/* design/tccie_pkg.sv */
package tccie_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CHAN_OUT_CTRL = 8'h04;
    localparam logic [7:0] OFS_IRQ_DMA_EN = 8'h0c;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h10;
    localparam logic [7:0] OFS_SHADOW_VIEW = 8'h18;
    // channel_output_control fields
    localparam int CTL_PRELOAD_BIT = 0;
    localparam int CTL_UPD_SEL_BIT = 2;
    localparam int CTL_DMA_SEL_BIT = 3;
    localparam int CTL_MAIN_IDLE_BIT = 8;
    localparam int CTL_COMPL_IDLE_BIT = 9;
    localparam logic [15:0] CTL_WMASK = 16'h000d;
    localparam logic [15:0] CTL_IDLE_MASK = 16'h0300;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    // irq_dma_enable fields
    localparam int EN_UPD_IRQ_BIT = 0;
    localparam int EN_CH1_IRQ_BIT = 1;
    localparam int EN_COM_IRQ_BIT = 5;
    localparam int EN_BRK_IRQ_BIT = 7;
    localparam int EN_UPD_DMA_BIT = 8;
    localparam int EN_CH1_DMA_BIT = 9;
    localparam logic [15:0] EN_WMASK = 16'h03a3;
    localparam logic [15:0] EN_RESET = 16'h0000;
    // status flag layout matches the irq enable bits
    localparam logic [15:0] STS_MASK = 16'h00a3;
    localparam logic [15:0] STS_RESET = 16'h0000;
    // output-control settings: chan_out_on, chan_compl_out_on, behaviour
    localparam int SET_W = 5;
    localparam logic [SET_W-1:0] SET_RESET = 5'h00;
endpackage

/* dv/tb_timer_ch_ctrl_irq_enable.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    miscompares++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_timer_ch_ctrl_irq_enable;
    logic core_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [3:0] ev = 4'h0;
    logic trig = 1'b0, compl = 1'b1, setWr = 1'b0;
    logic [1:0] lock = 2'h0;
    logic [4:0] newSet = 5'h00, actSet;
    logic mainIdle, complIdle, chDma, upDma, irq;
    int miscompares = 0, samples_checked = 0, cyc = 0;
    localparam logic [7:0] CTL = tccie_pkg::OFS_CHAN_OUT_CTRL;
    localparam logic [7:0] EN = tccie_pkg::OFS_IRQ_DMA_EN;
    localparam logic [7:0] STS = tccie_pkg::OFS_EVENT_STATUS;
    tccie_regs i_tccie_regs (.core_clk(core_clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .updateEvent(ev[0]), .ch1Event(ev[1]), .commutationGenerate(ev[2]),
        .breakEvent(ev[3]), .triggerInput(trig), .protectionLockLevel(lock),
        .hasComplOut(compl), .newSettings(newSet), .settingsWrite(setWr),
        .activeSettings(actSet), .ch1MainIdleLevel(mainIdle),
        .ch1ComplIdleLevel(complIdle), .chanDmaReq(chDma),
        .updateDmaReq(upDma), .irq(irq));
    // 40 mhz kernel clock
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // hang guard, far above the roughly 130 cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // idle cycle after each strobe so no signal is assigned twice per step
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge core_clk) wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        addr <= a; rd <= 1'b1;
        @(posedge core_clk) rd <= 1'b0;
        #1 `CHK("rdata", e, rdata)
        @(posedge core_clk);
    endtask
    // dma requests are combinational, looked at while the event is high
    task automatic pulse(input logic [3:0] v, input logic u, input logic c);
        ev <= v;
        #1 `CHK("dma", {u, c}, {upDma, chDma})
        @(posedge core_clk) ev <= 4'h0;
        @(posedge core_clk);
    endtask
    task automatic setw(input logic [4:0] v);
        newSet <= v; setWr <= 1'b1;
        @(posedge core_clk) setWr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic trigRise(input logic [4:0] e);
        trig <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK("active", e, actSet)
        trig <= 1'b0;
        @(posedge core_clk);
    endtask
    initial begin
        automatic int b[4] = '{0, 1, 5, 7};
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        rchk(CTL, tccie_pkg::CTL_RESET);
        rchk(EN, tccie_pkg::EN_RESET);
        wreg(8'h08, 16'hffff);
        rchk(8'h08, 16'h0000);
        wreg(EN, 16'hffff);
        rchk(EN, tccie_pkg::EN_WMASK);
        wreg(CTL, 16'hffff);
        rchk(CTL, 16'h030d);
        `CHK("idle", 2'h3, {mainIdle, complIdle})
        lock <= 2'h1;
        wreg(CTL, 16'h0000);
        rchk(CTL, 16'h0300);
        `CHK("idle", 2'h3, {mainIdle, complIdle})
        lock <= 2'h0;
        wreg(CTL, 16'h0000);
        `CHK("idle", 2'h0, {mainIdle, complIdle})
        setw(5'h15);
        `CHK("active", 5'h15, actSet)
        wreg(CTL, 16'h0001);
        setw(5'h0a);
        `CHK("active", 5'h15, actSet)
        rchk(tccie_pkg::OFS_SHADOW_VIEW, 16'h000a);
        wreg(EN, 16'h0000);
        pulse(4'h4, 1'b0, 1'b0);
        `CHK("active", 5'h0a, actSet)
        compl <= 1'b0;
        setw(5'h06);
        `CHK("active", 5'h06, actSet)
        compl <= 1'b1;
        setw(5'h11);
        trigRise(5'h06);
        wreg(CTL, 16'h0005);
        trigRise(5'h11);
        wreg(CTL, 16'h0004);
        setw(5'h1f);
        `CHK("active", 5'h1f, actSet)
        wreg(CTL, 16'h0000);
        wreg(STS, 16'h00a3);
        for (int i = 0; i < 4; i++) begin
            pulse(4'h1 << i, 1'b0, 1'b0);
            pulse(4'h0, 1'b0, 1'b0);
            `CHK("irq", 1'b0, irq)
            rchk(STS, 16'h0001 << b[i]);
            wreg(EN, 16'h0001 << b[i]);
            `CHK("irq", 1'b1, irq)
            wreg(STS, 16'h0001 << b[i]);
            `CHK("irq", 1'b0, irq)
            wreg(EN, 16'h0000);
        end
        wreg(EN, 16'h0001);
        pulse(4'h1, 1'b0, 1'b0);
        `CHK("irq", 1'b1, irq)
        wreg(STS, 16'h0001);
        wreg(EN, 16'h0300);
        pulse(4'h1, 1'b1, 1'b0);
        pulse(4'h2, 1'b0, 1'b1);
        wreg(CTL, 16'h0008);
        pulse(4'h1, 1'b1, 1'b1);
        pulse(4'h2, 1'b0, 1'b0);
        wreg(EN, 16'h0100);
        pulse(4'h1, 1'b1, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
